// file: testbench/ecc_error_trap_and_counter_tb_top.sv
// self-checking bench for the ecc trap and counter
`timescale 1ns/1ps
`default_nettype none
`include "ecc_trap_defines.svh"

module ecc_error_trap_and_counter_tb_top import ecc_trap_pkg::*; ;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  // a narrow counter makes saturation reachable in a short run
  localparam int CW = 4;
  localparam logic [31:0] SAT = 32'((1 << CW) - 1);
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic frame_on = 1'b0;
  logic hw_n = 1'b1;
  logic nv_mode = 1'b0;
  logic vol_en = 1'b1;
  logic cs_rst = 1'b0;
  logic sw_rst = 1'b0;
  logic clr = 1'b0;
  txn_kind_t txn = TXN_NONE;
  ecc_event_t ue = '0;
  reg_rd_req_t rq = '0;
  logic cs_n, sck, rd_valid, rd_hit, trap_valid;
  logic [31:0] rd_data, trap;
  logic [CW-1:0] cnt;
  logic [7:0] sts;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  spi_host_model u_host (.frame_on(frame_on), .cs_n_pin(cs_n), .sck_pin(sck));

  ecc_error_trap_and_counter #(.CNT_W(CW)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .cs_n_pin(cs_n), .sck_pin(sck),
    .hw_reset_n_pin(hw_n), .txn_kind(txn), .unit_event(ue), .nv_detect_mode(nv_mode),
    .vol_two_bit_en(vol_en), .cs_sig_reset(cs_rst), .sw_reset(sw_rst), .clear_cmd(clr),
    .rd_req(rq), .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit),
    .trap_valid(trap_valid), .error_address_trap(trap), .error_count(cnt),
    .ecc_status_reg(sts)
  );

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask

  task automatic state(input logic [31:0] t, input logic [31:0] c, input logic [7:0] s);
    chk(trap, t, "trap");
    chk(32'(cnt), c, "count");
    chk({24'h0, sts}, {24'h0, s}, "status");
    chk({31'h0, trap_valid}, {31'h0, s[3] | s[4]}, "trap valid");
  endtask

  // f holds one_bit, two_bit, ecc_off, main_array
  task automatic ev(input logic [31:0] a, input logic [3:0] f);
    ue = {1'h1, a, f};
    tick(1);
    ue.valid = 1'h0;
    tick(1);
  endtask

  task automatic rd(input logic [31:0] a, input logic hit, input logic [31:0] d);
    rq = {1'h1, a};
    tick(1);
    rq.valid = 1'h0;
    chk({31'h0, rd_valid}, 32'h1, "read valid");
    chk({31'h0, rd_hit}, {31'h0, hit}, "read hit");
    chk(rd_data, d, "read data");
    tick(1);
  endtask

  task automatic frame(input logic on);
    frame_on = on;
    txn = on ? TXN_ARRAY_READ : TXN_NONE;
    tick(20);
  endtask

  // 0 clear command, 1 software, 2 cs signalling, 3 hardware pin
  task automatic pulse(input int k);
    case (k)
      0: clr = 1'h1;
      1: sw_rst = 1'h1;
      2: cs_rst = 1'h1;
      default: hw_n = 1'h0;
    endcase
    tick(k == 3 ? 4 : 1);
    {clr, sw_rst, cs_rst, hw_n} = 4'h1;
    tick(4);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    state(32'h0, 32'h0, 8'h00);
    rd(`ECC_TRAP_ADDR, 1'h1, `ECC_TRAP_RESET);
    rd(`ECC_COUNT_ADDR, 1'h1, 32'h0);
    rd(`ECC_STATUS_ADDR, 1'h1, 32'h0);
    rd(32'h0000_00FF, 1'h0, 32'h0);
  endtask

  task automatic t_trap();
    frame(1'h1);
    ev(32'h1234_5678, 4'h9);
    state(32'h1234_5678, 32'h1, 8'h10);
    ev(32'h1234_567F, 4'h9);
    state(32'h1234_5678, 32'h1, 8'h10);
    ev(32'h0000_0300, 4'h9);
    state(32'h1234_5678, 32'h2, 8'h10);
    ev(32'h0000_0400, 4'h8);
    state(32'h1234_5678, 32'h2, 8'h10);
    txn = TXN_ECC_STATUS;
    ev(32'h0000_0500, 4'h9);
    state(32'h1234_5678, 32'h2, 8'h10);
    txn = TXN_OTHER;
    ev(32'h0000_0600, 4'h5);
    state(32'h1234_5678, 32'h2, 8'h10);
    frame(1'h0);
    // same unit as the last one seen in the previous frame: must count again
    frame(1'h1);
    ev(32'h0000_0400, 4'h9);
    state(32'h1234_5678, 32'h3, 8'h10);
    frame(1'h0);
    rd(`ECC_TRAP_ADDR, 1'h1, 32'h1234_5678);
    rd(`ECC_COUNT_ADDR, 1'h1, 32'h3);
    rd(`ECC_STATUS_ADDR, 1'h1, 32'h10);
  endtask

  // clear command and an event in one cycle: the event wins
  task automatic t_race();
    frame(1'h1);
    clr = 1'h1;
    ue = {1'h1, 32'h0000_0B00, 4'h9};
    tick(1);
    {clr, ue.valid} = 2'h0;
    tick(1);
    state(32'h0000_0B00, 32'h1, 8'h10);
    frame(1'h0);
  endtask

  task automatic t_clears();
    logic [31:0] a;
    pulse(0);
    state(32'h0, 32'h0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      a = 32'h0000_0A00 + 32'(k * 16);
      frame(1'h1);
      ev(a, 4'h9);
      state(a, 32'h1, 8'h10);
      frame(1'h0);
      pulse(k);
      state(32'h0, 32'h0, 8'h00);
    end
  endtask

  task automatic t_modes();
    nv_mode = 1'h1;
    frame(1'h1);
    ev(32'h0000_0700, 4'h9);
    state(32'h0, 32'h1, 8'h10);
    ev(32'h0000_0710, 4'h5);
    state(32'h0000_0710, 32'h2, 8'h18);
    frame(1'h0);
    pulse(0);
    vol_en = 1'h0;
    frame(1'h1);
    ev(32'h0000_0800, 4'h5);
    state(32'h0, 32'h0, 8'h00);
    ev(32'h0000_0810, 4'hB);
    state(32'h0, 32'h0, 8'h00);
    frame(1'h0);
    vol_en = 1'h1;
    nv_mode = 1'h0;
  endtask

  task automatic t_saturate();
    frame(1'h1);
    for (int i = 0; i < 17; i++) begin
      ev(32'h0001_0000 + 32'(i * 16), 4'h9);
    end
    state(32'h0001_0000, SAT, 8'h10);
    ev(32'h0002_0000, 4'h5);
    state(32'h0001_0000, SAT, 8'h18);
    frame(1'h0);
  endtask

  initial begin
    tick(6);
    rst_n = 1'h1;
    tick(2);
    t_reset();
    t_trap();
    t_race();
    t_clears();
    t_modes();
    t_saturate();
    close_out();
  end
endmodule

`default_nettype wire

// file: testbench/spi_host_model.sv
// host-side link model: chip select and serial clock of read frames
`timescale 1ns/1ps
`default_nettype none

module spi_host_model #(
  parameter int HALF_NS = 200
) (
  input wire logic frame_on,
  output logic cs_n_pin,
  output logic sck_pin
);
  // ----------------------------------------------------------------
  // frame generator
  // ----------------------------------------------------------------
  // clock only runs inside frames; odd offset keeps its phase unrelated to the core clock
  initial begin
    cs_n_pin = 1'b1;
    sck_pin = 1'b0;
    forever begin
      wait (frame_on);
      #37 cs_n_pin = 1'b0;
      while (frame_on) begin
        #HALF_NS sck_pin = ~sck_pin;
      end
      sck_pin = 1'b0;
      #HALF_NS cs_n_pin = 1'b1;
    end
  end
endmodule

`default_nettype wire

// file: verilog/ecc_error_trap_and_counter.sv
// ecc error address trap, error counter and status flags for array reads
//
// What this block does
// - hold a 32-bit trap of the data unit address of the first ecc error
// - trap only first error of enabled type; nonvolatile mode bit picks the type
// - trap changes only during array read transactions
// - trapped value is the accessed address within the failing 16-byte unit
// - several failing units in one read keep only the first address
// - units with ecc off while two-bit detection is off neither trap nor count
// - trap is valid only while status bit 3 or bit 4 is set
// - host reads trap with read-any-register and the device returns it
// - clear command, power-on, cs signalling, hardware, software reset clear trap
// - keep a 16-bit count of one-bit or two-bit errors on array reads
// - counter increments only for errors in the main array
// - counter changes only in read transactions, not on ecc status reads
// - counter saturates at all ones while ecc keeps working
// - in continuous reads every further failing unit counts until cs rises
// - repeats of the last failing unit do not count; each new transaction counts again
// - counter readable by read-any-register and zeroed by the same clears
// - status register is cleared by the same clearing events
// - two-bit flags only raised while volatile two-bit enable is one
`timescale 1ns/1ps
`default_nettype none
`include "ecc_trap_defines.svh"

module ecc_error_trap_and_counter import ecc_trap_pkg::*; #(
  parameter int CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic hw_reset_n_pin,
  input wire txn_kind_t txn_kind,
  input wire ecc_event_t unit_event,
  input wire logic nv_detect_mode,
  input wire logic vol_two_bit_en,
  input wire logic cs_sig_reset,
  input wire logic sw_reset,
  input wire logic clear_cmd,
  input wire reg_rd_req_t rd_req,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic rd_hit,
  output logic trap_valid,
  output logic [31:0] error_address_trap,
  output logic [CNT_W-1:0] error_count,
  output logic [7:0] ecc_status_reg
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic cs_s;
  logic sck_s;
  logic hwn_s;
  logic cs_d;
  logic sck_d;
  logic cs_rise;
  logic cs_fall;
  logic sck_rise;

  pin_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h5)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in({cs_n_pin, sck_pin, hw_reset_n_pin}),
    .pin_sync_out(pins_s)
  );

  assign cs_s = pins_s[2];
  assign sck_s = pins_s[1];
  assign hwn_s = pins_s[0];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cs_d <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      cs_d <= cs_s;
      sck_d <= sck_s;
    end
  end

  assign cs_rise = cs_s & ~cs_d;
  assign cs_fall = ~cs_s & cs_d;
  assign sck_rise = sck_s & ~sck_d;

  // ----------------------------------------------------------------
  // clearing events
  // ----------------------------------------------------------------
  logic clear_hard;
  logic clear_soft;

  // resets override any event; the clear command loses to a same-cycle event
  assign clear_hard = cs_sig_reset | sw_reset | ~hwn_s;
  assign clear_soft = clear_cmd;

  // ----------------------------------------------------------------
  // transaction tracking on the sampled link
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_WAIT,
    LINK_DATA
  } link_state_t;

  link_state_t state;
  link_state_t next_state;
  logic in_read;

  always_comb begin
    next_state = state;
    case (state)
      LINK_IDLE: begin
        if (cs_fall) begin
          next_state = LINK_WAIT;
        end
      end
      LINK_WAIT: begin
        if (cs_s) begin
          next_state = LINK_IDLE;
        end else if (sck_rise) begin
          next_state = LINK_DATA;
        end
      end
      LINK_DATA: begin
        if (cs_s) begin
          next_state = LINK_IDLE;
        end
      end
      default: begin
        next_state = LINK_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= LINK_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ecc status reads and other commands never reach the logs
  assign in_read = (state == LINK_DATA) && !cs_s && (txn_kind == TXN_ARRAY_READ);

  // ----------------------------------------------------------------
  // event qualification
  // ----------------------------------------------------------------
  logic ev_one;
  logic ev_two;
  logic ev_blind;
  logic ev_any;
  logic ev_trap;
  logic new_unit;
  logic count_hit;
  logic trap_locked;
  logic last_valid;
  logic [31-`ECC_UNIT_LSB:0] last_unit;

  assign ev_two = unit_event.two_bit & vol_two_bit_en;
  assign ev_one = unit_event.one_bit;
  assign ev_blind = unit_event.ecc_off & ~vol_two_bit_en;
  assign ev_any = unit_event.valid & in_read & (ev_one | ev_two) & ~ev_blind;
  assign ev_trap = ev_any & (nv_detect_mode ? ev_two : 1'b1);
  assign new_unit = !(last_valid && (last_unit == unit_event.addr[31:`ECC_UNIT_LSB]));
  assign count_hit = ev_any & unit_event.main_array & new_unit;

  // per-transaction memory of the last failing unit, counted or not (any main or non-main array error)
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      last_valid <= 1'b0;
      last_unit <= '0;
    end else if (cs_rise || state == LINK_IDLE) begin
      last_valid <= 1'b0;
    end else if (ev_any) begin
      last_valid <= 1'b1;
      last_unit <= unit_event.addr[31:`ECC_UNIT_LSB];
    end
  end

  // ----------------------------------------------------------------
  // error address trap
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n || clear_hard) begin
      error_address_trap <= `ECC_TRAP_RESET;
      trap_locked <= 1'b0;
    end else if (ev_trap && (!trap_locked || clear_soft)) begin
      // a clear command in the same cycle loses to the event, so it reopens the trap
      // full accessed address kept; the fault lies somewhere in its unit
      error_address_trap <= unit_event.addr;
      trap_locked <= 1'b1;
    end else if (clear_soft) begin
      error_address_trap <= `ECC_TRAP_RESET;
      trap_locked <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // saturating error counter
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  logic [CNT_W-1:0] count_base;

  assign count_base = clear_soft ? CNT_W'(`ECC_COUNT_RESET) : error_count;

  always_ff @(posedge core_clk) begin
    if (!rst_n || clear_hard) begin
      error_count <= CNT_W'(`ECC_COUNT_RESET);
    end else if (count_hit && count_base != CNT_MAX) begin
      error_count <= count_base + 1'b1;
    end else begin
      error_count <= count_base;
    end
  end

  // ----------------------------------------------------------------
  // ecc status flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n || clear_hard) begin
      ecc_status_reg <= `ECC_STATUS_RESET;
    end else begin
      if (clear_soft) begin
        ecc_status_reg <= `ECC_STATUS_RESET;
      end
      if (ev_any && ev_two) begin
        ecc_status_reg[`ECC_STS_TWO_BIT] <= 1'b1;
      end
      if (ev_any && ev_one) begin
        ecc_status_reg[`ECC_STS_ONE_BIT] <= 1'b1;
      end
    end
  end

  assign trap_valid = ecc_status_reg[`ECC_STS_TWO_BIT] | ecc_status_reg[`ECC_STS_ONE_BIT];

  // ----------------------------------------------------------------
  // read-any-register answer
  // ----------------------------------------------------------------
  function automatic logic [1:0] reg_select(input logic [31:0] addr);
    if (addr == `ECC_STATUS_ADDR) begin
      reg_select = 2'h1;
    end else if (addr == `ECC_TRAP_ADDR) begin
      reg_select = 2'h2;
    end else if (addr == `ECC_COUNT_ADDR) begin
      reg_select = 2'h3;
    end else begin
      reg_select = 2'h0;
    end
  endfunction

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data <= 32'h0000_0000;
      rd_valid <= 1'b0;
      rd_hit <= 1'b0;
    end else begin
      rd_valid <= rd_req.valid;
      rd_hit <= rd_req.valid && (reg_select(rd_req.addr) != 2'h0);
      if (!rd_req.valid) begin
        rd_data <= 32'h0000_0000;
      end else begin
        case (reg_select(rd_req.addr))
          2'h1: rd_data <= 32'(ecc_status_reg);
          2'h2: rd_data <= error_address_trap;
          2'h3: rd_data <= 32'(error_count);
          default: rd_data <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  trap_first_load_a: assert property (ev_trap && !trap_locked && !clear_hard
    |=> trap_locked && error_address_trap == $past(unit_event.addr))
    else $error("trap did not load the first failing address");

  trap_lock_hold_a: assert property (trap_locked && !clear_hard && !clear_soft
    |=> $stable(error_address_trap) && trap_locked)
    else $error("locked trap changed");

  trap_read_only_a: assert property (!in_read && !clear_hard && !clear_soft
    |=> $stable(error_address_trap))
    else $error("trap changed outside a read");

  clear_all_a: assert property (clear_hard
    |=> error_address_trap == 32'h0000_0000 && error_count == '0 && ecc_status_reg == 8'h00)
    else $error("reset event did not clear logs");

  count_step_a: assert property (count_hit && !clear_hard && !clear_soft
    && error_count != CNT_MAX |=> error_count == $past(error_count) + 1'b1)
    else $error("counter did not step by one");

  count_sat_a: assert property (error_count == CNT_MAX && !clear_hard && !clear_soft
    |=> error_count == CNT_MAX)
    else $error("counter left saturation");

  count_idle_a: assert property ((!in_read || !unit_event.main_array)
    && !clear_hard && !clear_soft |=> $stable(error_count))
    else $error("counter moved without a main array read error");

  two_bit_gate_a: assert property ($rose(ecc_status_reg[`ECC_STS_TWO_BIT])
    |-> $past(vol_two_bit_en))
    else $error("two-bit flag raised while detection disabled");

  trap_qualified_a: assert property (trap_locked |-> trap_valid)
    else $error("trap loaded without a status bit");

  read_answer_a: assert property (rd_req.valid && rd_req.addr == `ECC_TRAP_ADDR
    |=> rd_valid && rd_hit && rd_data == $past(error_address_trap))
    else $error("trap read answer wrong");

  race_set_wins_a: assert property (ev_trap && clear_soft && !clear_hard
    |=> trap_locked && error_address_trap == $past(unit_event.addr))
    else $error("event lost to a same-cycle clear");

  blind_unit_a: assert property (unit_event.ecc_off && !vol_two_bit_en
    && !clear_hard && !clear_soft |=> $stable(error_count) && $stable(error_address_trap))
    else $error("unit with ecc off changed the logs");

  one_bit_flag_a: assert property (ev_any && ev_one && !clear_hard
    |=> ecc_status_reg[`ECC_STS_ONE_BIT])
    else $error("one-bit flag not raised");

  count_clear_a: assert property (clear_soft && !count_hit && !clear_hard
    |=> error_count == '0)
    else $error("clear command left the counter");

  trap_load_c: cover property (ev_trap && !trap_locked);
  count_sat_c: cover property (count_hit && error_count == CNT_MAX);
  second_unit_c: cover property (trap_locked && count_hit);
  clear_race_c: cover property (clear_soft && ev_any);

endmodule

`default_nettype wire

// file: verilog/ecc_trap_defines.svh
// register addresses, field positions and reset values of the ecc trap and counter
`ifndef ECC_TRAP_DEFINES_SVH
`define ECC_TRAP_DEFINES_SVH

// ----------------------------------------------------------------
// read-any-register addresses
// ----------------------------------------------------------------
`define ECC_STATUS_ADDR 32'h0000_0089
`define ECC_TRAP_ADDR 32'h0000_008A
`define ECC_COUNT_ADDR 32'h0000_008B

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ECC_STS_TWO_BIT 3
`define ECC_STS_ONE_BIT 4
`define ECC_UNIT_LSB 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ECC_TRAP_RESET 32'h0000_0000
`define ECC_COUNT_RESET 16'h0000
`define ECC_STATUS_RESET 8'h00

`endif

// file: verilog/ecc_trap_pkg.sv
// types shared by the ecc trap and counter block
package ecc_trap_pkg;

  // ----------------------------------------------------------------
  // transaction kind reported by the command decoder
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TXN_NONE,
    TXN_ARRAY_READ,
    TXN_ECC_STATUS,
    TXN_OTHER
  } txn_kind_t;

  // ----------------------------------------------------------------
  // one result per 16-byte data unit from the ecc decoder
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic one_bit;
    logic two_bit;
    logic ecc_off;
    logic main_array;
  } ecc_event_t;

  // ----------------------------------------------------------------
  // read-any-register request from the command decoder
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } reg_rd_req_t;

endpackage

// file: verilog/pin_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      pin_sync_out <= RESET_VAL;
    end else begin
      meta <= pin_in;
      pin_sync_out <= meta;
    end
  end

endmodule

`default_nettype wire
